//--- shared/pio_pkg.sv
package pio_pkg;

  // Geometry of the nine ports, each held in a sixteen-bit slot.
  localparam int NUM_PORTS = 9;
  localparam int PORT_W = 16;
  localparam int THRESH_W = 13;

  // Register map: per port a stride of sixteen bytes with three words.
  localparam logic [7:0] PORT_STRIDE = 8'h10;
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_DIR = 2'h1;
  localparam logic [1:0] SEL_ODS = 2'h2;
  localparam logic [7:0] OFF_THRESH = 8'h90;

  // Field positions inside the threshold register.
  localparam int TH_P0L = 0;
  localparam int TH_P0H = 1;
  localparam int TH_P1L = 2;
  localparam int TH_P1H = 3;
  localparam int TH_P4 = 4;
  localparam int TH_P7 = 5;
  localparam int TH_P8 = 6;
  localparam int TH_P2 = 7;
  localparam int TH_P3 = 9;
  localparam int TH_P5 = 11;

  // Implemented lines per port, port 8 first and port 0 last.
  localparam logic [8:0][15:0] PORT_MASK = {16'h00FF, 16'h00FF, 16'h00FF, 16'hFFFF,
    16'h00FF, 16'hBFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  // Lines with an output driver; port 5 has none.
  localparam logic [8:0][15:0] OUT_MASK = {16'h00FF, 16'h00FF, 16'h00FF, 16'h0000,
    16'h00FF, 16'hBFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  // Lines whose driver may be switched to open drain.
  localparam logic [8:0][15:0] OD_MASK = {16'h00FF, 16'h00FF, 16'h00FF, 16'h0000,
    16'h00FF, 16'hBFFF, 16'hFFFF, 16'h0000, 16'h0000};

  // Values after reset.
  localparam logic [15:0] RST_LATCH = 16'h0000;
  localparam logic [15:0] RST_DIR = 16'h0000;
  localparam logic [15:0] RST_ODS = 16'h0000;
  localparam logic [12:0] RST_THRESH = 13'h0000;

  // One state time is two clock periods; the count rounds up, at least one.
  localparam int CLK_PERIOD_NS = 40;
  localparam int STATE_TIME_NS = 80;
  localparam int STATE_CYCLES_RAW = (STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATE_CYCLES = (STATE_CYCLES_RAW < 1) ? 1 : STATE_CYCLES_RAW;

endpackage

//--- hw/state_tick.sv
`timescale 1ns/1ps
module state_tick
  import pio_pkg::*;
#(
  parameter int CYCLES = STATE_CYCLES
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  output logic tick // One-cycle pulse once per state time.
);

  // Divider count and the registered pulse.
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } tick_state_t;

  tick_state_t s;
  tick_state_t next_s;

  // Count down and pulse when the count wraps.
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == 8'h00) begin
      next_s.cnt = 8'(CYCLES - 1);
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt - 8'h01;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule

//--- hw/parallel_io_ports.sv
`timescale 1ns/1ps
// Functional notes
// - Ports sized per map; port three bit fourteen absent.
// - Port five is input only, never driven.
// - Per-bit open drain drives only low.
// - Every pin sampled once per state time.
// - Input pin: write hits latch if the line has a driver, read returns pin.
// - Input pin modify cycle reads pin, writes latch.
// - Output pin follows latch; read returns latch.
// - Output pin modify cycle reads latch, writes latch.
// - Threshold TTL default, CMOS select per byte.
// - Direction and drive independent of threshold.
// - Alternate output reaches pin only when output.
// - Alternate output ANDed with latch except PWM.
// - All directions are input after reset.
// - Alternate input sees sampled pin, whatever the direction.
// - Hardware may override direction for bus lines.
// - One alternate function per line.
module parallel_io_ports
  import pio_pkg::*;
(
  input wire logic pclk, // System clock, 25 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic [8:0][15:0] pin_in, // Pin levels seen at the pads.
  output logic [8:0][15:0] pin_out, // Level driven onto each pin.
  output logic [8:0][15:0] pin_oe, // High while the pin is driven.
  input wire logic [8:0][15:0] alt_out_en, // Alternate output enabled per line.
  input wire logic [8:0][15:0] alt_out_data, // Alternate output data per line.
  input wire logic [8:0][15:0] alt_pwm_sel, // Alternate output is a PWM signal.
  input wire logic [8:0][15:0] alt_dir_auto, // Hardware owns the direction.
  input wire logic [8:0][15:0] alt_dir_hw, // Direction chosen by hardware.
  output logic [8:0][15:0] alt_in, // Sampled pin levels for alternate inputs.
  output logic [12:0] input_threshold_select // CMOS threshold per byte when high.
);

  // Whole state of the block as one record.
  typedef struct packed {
    logic [8:0][15:0] latch; // Output latches.
    logic [8:0][15:0] dir; // Direction bits, high for output.
    logic [8:0][15:0] ods; // Open-drain select bits.
    logic [8:0][15:0] in_latch; // Pin levels sampled each state time.
    logic [8:0][15:0] pin_out; // Registered pin level.
    logic [8:0][15:0] pin_oe; // Registered pin enable.
    logic [12:0] thresh; // Threshold selects.
    logic [31:0] prdata; // Registered read data.
    logic pready; // Registered ready.
    logic pslverr; // Registered error.
  } pio_state_t;

  pio_state_t s;
  pio_state_t next_s;

  logic tick; // State time pulse.
  logic [8:0][15:0] eff_dir; // Direction after any hardware override.
  logic [8:0][15:0] drive_val; // Level that the line would drive.
  logic [8:0][15:0] read_view; // Value software reads from a data word.
  logic [3:0] port_idx; // Port addressed by the bus.
  logic [1:0] reg_sel; // Word within the port.
  logic addr_ok; // Address hits a mapped word.
  logic is_thresh; // Address hits the threshold word.
  logic access; // Access phase of a transfer.
  logic wr_commit; // Edge at which a write takes effect.

  // Divider that marks each state time.
  state_tick #(
    .CYCLES(STATE_CYCLES)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // Address decode for the APB slave.
  always_comb begin
    port_idx = paddr[7:4];
    reg_sel = paddr[3:2];
    is_thresh = (paddr == OFF_THRESH);
    addr_ok = is_thresh || ((port_idx < 4'(NUM_PORTS)) && (reg_sel != 2'h3)
      && (paddr[1:0] == 2'h0));
    access = psel && penable;
    wr_commit = access && s.pready && pwrite && !s.pslverr;
  end

  // Per-line drive and read values.
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      // Bus lines may have their direction switched by hardware.
      eff_dir[p] = ((alt_dir_auto[p] & alt_dir_hw[p]) | (~alt_dir_auto[p] & s.dir[p]))
        & OUT_MASK[p];
      // A PWM output bypasses the latch, other alternates are ANDed with it.
      drive_val[p] = (alt_out_en[p] & alt_pwm_sel[p] & alt_out_data[p])
        | (alt_out_en[p] & ~alt_pwm_sel[p] & alt_out_data[p] & s.latch[p])
        | (~alt_out_en[p] & s.latch[p]);
      // Output lines read back the latch, input lines read the sampled pin.
      read_view[p] = ((eff_dir[p] & s.latch[p]) | (~eff_dir[p] & s.in_latch[p]))
        & PORT_MASK[p];
    end
  end

  // Next-state logic: sampling, pin drive and register access.
  always_comb begin
    next_s = s;
    // Pins are captured once per state time whatever their direction.
    if (tick) begin
      next_s.in_latch = pin_in & PORT_MASK;
    end
    // Drive stage: an open-drain line only drives when its level is low.
    for (int p = 0; p < NUM_PORTS; p++) begin
      next_s.pin_out[p] = drive_val[p] & OUT_MASK[p];
      next_s.pin_oe[p] = eff_dir[p] & ~(s.ods[p] & drive_val[p]);
    end
    // Ready rises one cycle into the access phase and lasts one cycle.
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    if (access && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !addr_ok;
      next_s.prdata = 32'h0000_0000;
      if (!pwrite && addr_ok) begin
        if (is_thresh) begin
          next_s.prdata = {19'h0_0000, s.thresh};
        end else begin
          unique case (reg_sel)
            // Data word: a modify cycle starts from this view.
            SEL_DATA: next_s.prdata = {16'h0000, read_view[port_idx]};
            SEL_DIR: next_s.prdata = {16'h0000, s.dir[port_idx]};
            SEL_ODS: next_s.prdata = {16'h0000, s.ods[port_idx]};
            default: next_s.prdata = 32'h0000_0000;
          endcase
        end
      end
    end
    // Writes take effect at the edge where ready is seen high.
    if (wr_commit) begin
      if (is_thresh) begin
        next_s.thresh = pwdata[12:0];
      end else begin
        unique case (reg_sel)
          // A write lands in the latch of every line with a driver, whatever the direction.
          SEL_DATA: next_s.latch[port_idx] = pwdata[15:0] & OUT_MASK[port_idx];
          SEL_DIR: next_s.dir[port_idx] = pwdata[15:0] & OUT_MASK[port_idx];
          SEL_ODS: next_s.ods[port_idx] = pwdata[15:0] & OD_MASK[port_idx];
          default: next_s.latch[port_idx] = s.latch[port_idx];
        endcase
      end
    end
  end

  // State register; everything clears on reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register.
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign pin_out = s.pin_out;
  assign pin_oe = s.pin_oe;
  assign alt_in = s.in_latch;
  assign input_threshold_select = s.thresh;

  // A write to the port zero data word committed at a ready edge.
  sequence wr_data0_s;
    psel && penable && pready && pwrite && !pslverr && (paddr == 8'h00);
  endsequence

  // A write to the port zero direction word committed at a ready edge.
  sequence wr_dir0_s;
    psel && penable && pready && pwrite && !pslverr && (paddr == 8'h04);
  endsequence

  // A read of the port two data word being answered.
  sequence rd_data2_s;
    psel && penable && !pready && !pwrite && (paddr == 8'h20);
  endsequence

  // The port zero latch holds the written value after the commit edge.
  latch_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_data0_s |=> s.latch[0] == $past(pwdata[15:0]))
    else $error("port zero latch did not take the written data");

  // The port zero direction holds the written value after the commit edge.
  dir_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_dir0_s |=> s.dir[0] == $past(pwdata[15:0]))
    else $error("port zero direction did not take the written data");

  // Reading the port two data word returns latch or pin by direction.
  data_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_data2_s |=> pready && (prdata[15:0] == (($past(eff_dir[2]) & $past(s.latch[2]))
      | (~$past(eff_dir[2]) & $past(s.in_latch[2])))))
    else $error("port two read returned the wrong source");

  // Port five is never driven and port three bit fourteen never exists.
  no_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_oe[5] == 16'h0000) && (pin_oe[3][14] == 1'b0) && (pin_out[3][14] == 1'b0))
    else $error("an absent or input-only line is driven");

  // An open-drain line never drives a high level.
  od_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ((pin_oe & pin_out & $past(s.ods)) == '0))
    else $error("open-drain line drove high");

  // A driven line was an output line one cycle earlier.
  oe_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ((pin_oe & ~$past(eff_dir)) == '0))
    else $error("line driven while its direction is input");

  // A non-PWM alternate output is high only where the latch was high.
  alt_and_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ((pin_out & $past(alt_out_en & ~alt_pwm_sel & ~s.latch)) == '0))
    else $error("alternate output passed a cleared latch");

  // Each state time pulse captures the implemented pin levels.
  sample_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> alt_in == ($past(pin_in) & PORT_MASK))
    else $error("pins were not sampled on the state time");

  // Directions, latches and thresholds are cleared just after reset.
  reset_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (s.dir == '0) && (s.latch == '0) && (s.thresh == '0))
    else $error("control state not cleared by reset");

  // The bus checks below follow the two-cycle access phase of this slave.
  // A setup cycle: select high, enable still low.
  sequence setup_s;
    psel && !penable;
  endsequence

  // The first access cycle, before the slave answers.
  sequence wait_s;
    psel && penable && !pready;
  endsequence

  // A write to the threshold word committed at a ready edge.
  sequence wr_thresh_s;
    psel && penable && pready && pwrite && !pslverr && (paddr == OFF_THRESH);
  endsequence

  // A read of the port two direction word being answered.
  sequence rd_dir2_s;
    psel && penable && !pready && !pwrite && (paddr == 8'h24);
  endsequence

  // An access to a word that the map does not hold.
  sequence bad_addr_s;
    psel && penable && !pready && (paddr != OFF_THRESH)
      && ((paddr[7:4] > 4'h8) || (paddr[3:2] == 2'h3) || (paddr[1:0] != 2'h0));
  endsequence

  // A refused transfer finishing at its ready edge.
  sequence err_done_s;
    psel && penable && pready && pslverr;
  endsequence

  // Ready comes in the second access cycle, never later.
  ready_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_s ##1 wait_s |=> pready)
    else $error("ready did not come in the second access cycle");

  // Ready is a single-cycle pulse per transfer.
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready stood for more than one cycle");

  // An error response only comes together with ready.
  err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response without ready");

  // A word outside the map is answered with an error.
  err_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    bad_addr_s |=> pready && pslverr)
    else $error("unmapped word was not refused");

  // A refused transfer returns zero and leaves every control bit alone.
  err_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    err_done_s |-> (prdata == 32'h0000_0000) ##1 ($stable(s.latch) && $stable(s.dir)
      && $stable(s.ods) && $stable(s.thresh)))
    else $error("refused transfer returned data or changed state");

  // No latch or direction bit exists on a line without a driver.
  latch_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((s.latch | s.dir) & ~OUT_MASK) == '0)
    else $error("latch or direction bit set on a line without driver");

  // No open-drain bit exists on a line without that option.
  ods_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.ods & ~OD_MASK) == '0)
    else $error("open-drain bit set on a line without that option");

  // The threshold word holds the written selects after the commit edge.
  thresh_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_thresh_s |=> s.thresh == $past(pwdata[12:0]))
    else $error("threshold word did not take the written data");

  // Reading the port two direction word returns the direction bits.
  dir_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_dir2_s |=> pready && (prdata[15:0] == $past(s.dir[2])))
    else $error("port two direction read returned the wrong value");

  // A push-pull output line is driven one cycle later.
  oe_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> (($past(eff_dir & ~s.ods) & ~pin_oe) == '0))
    else $error("push-pull output line not driven");

  // A plain output line shows its latch one cycle later.
  out_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> (($past(eff_dir & ~alt_out_en) & (pin_out ^ $past(s.latch))) == '0))
    else $error("output line does not follow its latch");

  // A PWM alternate output passes to the pin without the latch.
  pwm_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> (($past(eff_dir & alt_out_en & alt_pwm_sel)
      & (pin_out ^ $past(alt_out_data))) == '0))
    else $error("PWM output did not reach the pin");

  // A push-pull line that hardware turns to output is driven one cycle later.
  hw_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> (($past(alt_dir_auto & alt_dir_hw & OUT_MASK & ~s.ods) & ~pin_oe) == '0))
    else $error("hardware direction override not applied");

  // Between state times the sampled pin levels stay put.
  sample_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !tick |=> $stable(alt_in))
    else $error("pins sampled outside a state time");

  // A state time spans more than one clock, so pulses never touch.
  tick_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> !tick)
    else $error("state time pulses on two cycles in a row");

endmodule

//--- verif/pin_world.sv
`timescale 1ns/1ps
// Outside world of the port pins: pads, pull-ups and external drivers.
module pin_world (
  input wire logic [8:0][15:0] pin_out, // Level the block drives.
  input wire logic [8:0][15:0] pin_oe, // High where the block drives.
  input wire logic [8:0][15:0] ext_en, // High where an outside device drives.
  input wire logic [8:0][15:0] ext_val, // Level of the outside device.
  output logic [8:0][15:0] pin_in // Resolved wire level.
);
  // A driven pin shows the block level, else an outside driver, else the pull-up.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
  import pio_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr; // Bus and clocking.
  logic [7:0] paddr; // Byte address.
  logic [31:0] pwdata, prdata, r; // Bus data and last read word.
  logic e; // Last error response.
  logic [8:0][15:0] pin_in, pin_out, pin_oe, alt_in, ext_en, ext_val; // Pin side.
  logic [8:0][15:0] aoe, aod, apwm, aauto, ahw; // Alternate function inputs.
  logic [12:0] thr; // Threshold selects.
  int n_mismatch = 0; // Mismatches seen.
  int n_checks = 0; // Comparisons made.

  // Clock of 40 ns period.
  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end

  parallel_io_ports i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .alt_out_en(aoe), .alt_out_data(aod), .alt_pwm_sel(apwm), .alt_dir_auto(aauto),
    .alt_dir_hw(ahw), .alt_in(alt_in), .input_threshold_select(thr));
  pin_world i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));

  // Byte address of one register word of a port.
  function automatic logic [7:0] ra(input int p, input logic [1:0] s);
    return 8'(p) * PORT_STRIDE + 8'(s) * 8'h04;
  endfunction

  // Compares a seen value with the expected one.
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  // Reads one word and compares its low half.
  task rdchk(input string name, input logic [7:0] a, input logic [15:0] x);
    xfer(1'h0, a, 16'h0000);
    chk(name, r[15:0], x);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    wrap_up;
  end

  // Main sequence of tests.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {aoe, aod, apwm, aauto, ahw, ext_en, ext_val} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int p = 0; p < NUM_PORTS; p++) begin
      rdchk("dir rst", ra(p, SEL_DIR), 16'h0000);
      rdchk("ods rst", ra(p, SEL_ODS), 16'h0000);
    end
    rdchk("thr rst", OFF_THRESH, 16'h0000);
    ext_en[2] <= 16'hFFFF;
    ext_val[2] <= 16'hA5C3;
    ext_en[4] <= 16'h00FF;
    ext_val[4] <= 16'h003C;
    xfer(1'h1, ra(2, SEL_DATA), 16'h1234);
    repeat (6) @(posedge pclk);
    chk("alt_in p2", alt_in[2], 16'hA5C3);
    rdchk("p2 in", ra(2, SEL_DATA), 16'hA5C3);
    xfer(1'h0, ra(4, SEL_DATA), 16'h0000);
    xfer(1'h1, ra(4, SEL_DATA), r[15:0] | 16'h0001);
    ext_en <= '0;
    xfer(1'h1, ra(2, SEL_DIR), 16'hFFFF);
    xfer(1'h1, ra(4, SEL_DIR), 16'h00FF);
    xfer(1'h1, ra(8, SEL_DIR), 16'h00FF);
    rdchk("p4 rmw", ra(4, SEL_DATA), 16'h003D);
    rdchk("p2 out", ra(2, SEL_DATA), 16'h1234);
    rdchk("p8 latch", ra(8, SEL_DATA), 16'h0000);
    chk("p2 oe", pin_oe[2], 16'hFFFF);
    chk("p2 pin", pin_out[2], 16'h1234);
    xfer(1'h0, ra(2, SEL_DATA), 16'h0000);
    xfer(1'h1, ra(2, SEL_DATA), r[15:0] | 16'h00F0);
    rdchk("p2 rmw", ra(2, SEL_DATA), 16'h12F4);
    xfer(1'h1, ra(2, SEL_ODS), 16'h00FF);
    xfer(1'h1, ra(0, SEL_ODS), 16'hFFFF);
    repeat (6) @(posedge pclk);
    chk("p2 od oe", pin_oe[2], 16'hFF0B);
    chk("p2 loop", alt_in[2], 16'h12F4);
    rdchk("p0 ods", ra(0, SEL_ODS), 16'h0000);
    xfer(1'h1, OFF_THRESH, 16'h1FFF);
    rdchk("thr", OFF_THRESH, 16'h1FFF);
    chk("thr out", {3'h0, thr}, 16'h1FFF);
    chk("oe cmos", pin_oe[2], 16'hFF0B);
    xfer(1'h1, ra(7, SEL_DATA), 16'h000F);
    aoe[7] <= 16'h00FF;
    aod[7] <= 16'h00FF;
    apwm[7] <= 16'h00C0;
    repeat (4) @(posedge pclk);
    chk("alt hiz", pin_oe[7], 16'h0000);
    xfer(1'h1, ra(7, SEL_DIR), 16'h00FF);
    repeat (2) @(posedge pclk);
    chk("alt oe", pin_oe[7], 16'h00FF);
    chk("alt and", pin_out[7], 16'h00CF);
    xfer(1'h1, ra(0, SEL_DIR), 16'h00FF);
    xfer(1'h1, ra(0, SEL_DATA), 16'hFFFF);
    aoe[0] <= 16'h00FF;
    aod[0] <= 16'h005A;
    repeat (2) @(posedge pclk);
    chk("p0 alt", pin_out[0], 16'hFF5A);
    chk("p0 oe", pin_oe[0], 16'h00FF);
    aauto[1] <= 16'hFFFF;
    ahw[1] <= 16'hFFFF;
    repeat (4) @(posedge pclk);
    chk("hw dir", pin_oe[1], 16'hFFFF);
    rdchk("sw dir", ra(1, SEL_DIR), 16'h0000);
    for (int p = 0; p < NUM_PORTS; p++) begin
      xfer(1'h1, ra(p, SEL_DIR), 16'hFFFF);
      rdchk("dir size", ra(p, SEL_DIR), OUT_MASK[p]);
    end
    chk("p5 oe", pin_oe[5], 16'h0000);
    xfer(1'h0, 8'hA0, 16'h0000);
    chk("unmapped", {15'h0000, e}, 16'h0001);
    chk("unmapped rd", r[15:0], 16'h0000);
    xfer(1'h1, 8'h0C, 16'hFFFF);
    chk("unmapped wr", {15'h0000, e}, 16'h0001);
    // Second reset in mid-run: control state must clear again.
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk("oe rst", pin_oe[2], 16'h0000);
    rdchk("thr rst2", OFF_THRESH, 16'h0000);
    rdchk("ods rst2", ra(2, SEL_ODS), 16'h0000);
    xfer(1'h1, ra(2, SEL_DIR), 16'hFFFF);
    rdchk("latch rst", ra(2, SEL_DATA), 16'h0000);
    wrap_up;
  end
endmodule
